// ### timer_regs_pkg.sv
// Shared constants of the timer register slice.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
package timer_regs_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] addr_flag_set = 8'h14;
	localparam logic [7:0] addr_counter = 8'h24;
	localparam logic [7:0] addr_routing = 8'h28;
	localparam logic [7:0] addr_out_enables = 8'h7c;
	localparam logic [7:0] addr_fault_status = 8'h80;
	localparam logic [7:0] addr_fault_clear = 8'h84;
	localparam logic [7:0] addr_fault_enables = 8'h88;
	localparam logic [7:0] addr_flags = 8'h8c;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int flag_cc1_pos = 5;
	localparam int flag_cc2_pos = 6;
	localparam int flag_ovf_pos = 8;
	localparam int route_chan_pos = 0;
	localparam int route_comp_pos = 8;
	localparam int route_loc_pos = 16;
	localparam int gen_chan_pos = 0;
	localparam int gen_comp_pos = 3;
	localparam logic [2:0] loc_max = 3'h5;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [15:0] count_reset = 16'h0000;
	localparam logic [31:0] reg_reset = 32'h0000_0000;

	typedef enum logic [1:0] {
		bus_idle = 2'b00,
		bus_answer = 2'b01
	} bus_state_type;

endpackage : timer_regs_pkg

// ### capture_overflow.sv
// Detects capture buffer overflow for one channel.
// Assumes capture and read strobes are single-cycle pulses on clk_sys_i.
`timescale 1ns/1ns
module capture_overflow (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic capture_i,
	input wire logic read_i,
	output logic overflow_o
);
	logic [1:0] unread_q;

	// Unread values held in the value/buffer pair
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			unread_q <= 2'h0;
		end else if (capture_i && !read_i && unread_q != 2'h2) begin
			unread_q <= unread_q + 2'h1;
		end else if (read_i && !capture_i && unread_q != 2'h0) begin
			unread_q <= unread_q - 2'h1;
		end
	end

	// Full pair plus a new capture displaces an unread value
	assign overflow_o = capture_i && unread_q == 2'h2 && !read_i;
endmodule : capture_overflow

// ### dead_time_gate.sv
// Output gating of the dead-time unit for one channel pair.
// Assumes pwm_i is the compare output of the channel.
`timescale 1ns/1ns
module dead_time_gate (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic pwm_i,
	input wire logic gen_primary_i,
	input wire logic gen_comp_i,
	input wire logic pin_primary_i,
	input wire logic pin_comp_i,
	input wire logic fault_i,
	output logic primary_o,
	output logic comp_o
);
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			primary_o <= 1'b0;
			comp_o <= 1'b0;
		end else begin
			// Fault forces both switches off
			primary_o <= pwm_i && gen_primary_i && pin_primary_i && !fault_i;
			comp_o <= !pwm_i && gen_comp_i && pin_comp_i && !fault_i;
		end
	end
endmodule : dead_time_gate

// ### timer_dead_time_route_regs.sv
// Register slice of a three-channel timer with dead-time output gating.
// Assumes an Avalon-MM master on clk_sys_i and synchronous event inputs.
//
// How it works
// R1: Writing one to flag-set bits 10..8 sets capture overflow flag of channel 2..0.
// R2: Writing one to flag-set bits 6, 5 sets channel 2, 1 event flag.
// R3: Zero writes leave flags alone; flag-set reads as zero.
// R4: Capture overflow flag rises when a new capture displaces an unread value.
// R5: Counter register holds 16-bit count, resets to zero, software and hardware write it.
// R6: Location field bits 18:16 selects pin location 0 to 5.
// R7: Routing bits 10..8 connect complementary outputs 2..0 to pins, off at reset.
// R8: Routing bits 2..0 connect channel outputs 2..0 to pins, off at reset.
// R9: Generation bits 5..3 gate complementary outputs of channels 2..0.
// R10: Generation bits 2..0 gate primary outputs of channels 2..0.
// R11: Each of three channels gets an extra complementary output.
// R12: Fault bit 3 sets on core lockup while its enable is one.
// R13: Fault bit 2 sets on debugger fault while its enable is one.
// R14: Fault bit 1 sets on event input 1 fault while its enable is one.
// R15: Fault bit 0 sets on event input 0 fault while its enable is one.
// R16: Fault bits are read-only, cleared only through the fault-clear register.
// R17: Software writes zero to reserved bits.
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ns
module timer_dead_time_route_regs (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic count_tick_i,
	input wire logic [2:0] capture_i,
	input wire logic [2:0] capture_read_i,
	input wire logic [2:0] pwm_i,
	input wire logic core_lockup_i,
	input wire logic debugger_fault_i,
	input wire logic [1:0] reflex_event_fault_i,
	output logic [2:0] chan_pin_o,
	output logic [2:0] comp_pin_o,
	output logic [2:0] pin_location_o,
	output logic [15:0] count_value_o
);
	import timer_regs_pkg::*;

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	bus_state_type bus_state_q;
	logic [31:0] readdata_q;
	logic [15:0] count_value_q;
	logic [2:0] location_q;
	logic [2:0] chan_pin_enable_q;
	logic [2:0] comp_pin_enable_q;
	logic [2:0] chan_gen_enable_q;
	logic [2:0] comp_gen_enable_q;
	logic [3:0] fault_flags_q;
	logic [3:0] fault_enables_q;
	logic [2:0] overflow_flags_q;
	logic [2:1] event_flags_q;

	// ----------------------------------------
	// Internal nets
	// ----------------------------------------
	logic [2:0] overflow_evt;
	logic [2:0] gated_chan;
	logic [2:0] gated_comp;
	logic [3:0] fault_src;
	logic fault_any;
	logic wr_go;
	logic rd_go;
	logic [31:0] wdata;
	logic [31:0] count_merged;

	// ----------------------------------------
	// Decoded register selects
	// ----------------------------------------
	logic wr_flag_set;
	logic wr_counter;
	logic wr_routing;
	logic wr_out_enables;
	logic wr_fault_clear;
	logic wr_fault_enables;
	logic rd_counter;
	logic rd_routing;
	logic rd_out_enables;
	logic rd_fault_status;
	logic rd_fault_enables;
	logic rd_flags;

	// Byte-lane merge of write data with current contents
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
		return a == reg_addr;
	endfunction : hit

	// ----------------------------------------
	// Avalon slave handshake
	// ----------------------------------------
	// One wait state per access keeps read data registered
	// Reads are captured on entry, writes land in the answer cycle
	assign wr_go = avs_write_i && bus_state_q == bus_answer;
	assign rd_go = avs_read_i && bus_state_q == bus_idle;
	assign wdata = merge(reg_reset, avs_writedata_i, avs_byteenable_i);

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			bus_state_q <= bus_idle;
			avs_waitrequest_o <= 1'b1;
		end else begin
			unique case (bus_state_q)
				bus_idle: begin
					if (avs_read_i || avs_write_i) begin
						bus_state_q <= bus_answer;
						avs_waitrequest_o <= 1'b0;
					end
				end
				bus_answer: begin
					bus_state_q <= bus_idle;
					avs_waitrequest_o <= 1'b1;
				end
				// Unused codes fall back to idle so the bus cannot lock up
				default: begin
					bus_state_q <= bus_idle;
					avs_waitrequest_o <= 1'b1;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Register decode
	// ----------------------------------------
	// Each write strobe fires once, in the answer cycle
	assign wr_flag_set = wr_go && hit(avs_address_i, addr_flag_set);
	assign wr_counter = wr_go && hit(avs_address_i, addr_counter);
	assign wr_routing = wr_go && hit(avs_address_i, addr_routing);
	assign wr_out_enables = wr_go && hit(avs_address_i, addr_out_enables);
	assign wr_fault_clear = wr_go && hit(avs_address_i, addr_fault_clear);
	assign wr_fault_enables = wr_go && hit(avs_address_i, addr_fault_enables);

	// Read selects are qualified by rd_go in the read mux
	assign rd_counter = hit(avs_address_i, addr_counter);
	assign rd_routing = hit(avs_address_i, addr_routing);
	assign rd_out_enables = hit(avs_address_i, addr_out_enables);
	assign rd_fault_status = hit(avs_address_i, addr_fault_status);
	assign rd_fault_enables = hit(avs_address_i, addr_fault_enables);
	assign rd_flags = hit(avs_address_i, addr_flags);

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	// Data captured on entry stands through the answer cycle
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			readdata_q <= reg_reset;
		end else if (rd_go) begin
			readdata_q <= reg_reset;
			if (rd_counter) begin
				readdata_q[15:0] <= count_value_q; // [R5]
			end
			if (rd_routing) begin
				readdata_q[route_loc_pos +: 3] <= location_q;
				readdata_q[route_comp_pos +: 3] <= comp_pin_enable_q;
				readdata_q[route_chan_pos +: 3] <= chan_pin_enable_q;
			end
			if (rd_out_enables) begin
				readdata_q[gen_comp_pos +: 3] <= comp_gen_enable_q;
				readdata_q[gen_chan_pos +: 3] <= chan_gen_enable_q;
			end
			if (rd_fault_status) begin
				readdata_q[3:0] <= fault_flags_q; // [R16]
			end
			if (rd_fault_enables) begin
				readdata_q[3:0] <= fault_enables_q;
			end
			if (rd_flags) begin
				readdata_q[flag_ovf_pos +: 3] <= overflow_flags_q;
				readdata_q[flag_cc2_pos] <= event_flags_q[2];
				readdata_q[flag_cc1_pos] <= event_flags_q[1];
			end
			// Flag-set, fault-clear and unmapped addresses read zero [R3]
		end
	end
	assign avs_readdata_o = readdata_q;

	// ----------------------------------------
	// Counter
	// ----------------------------------------
	// Only the low two byte lanes reach the 16-bit count
	assign count_merged = merge({16'h0000, count_value_q}, avs_writedata_i, avs_byteenable_i);

	// A bus write wins over a tick in the same cycle
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			count_value_q <= count_reset; // [R5]
		end else if (wr_counter) begin
			count_value_q <= count_merged[15:0]; // [R5]
		end else if (count_tick_i) begin
			count_value_q <= count_value_q + 16'h0001; // [R5]
		end
	end
	assign count_value_o = count_value_q;

	// ----------------------------------------
	// Pin routing
	// ----------------------------------------
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			location_q <= 3'h0;
			comp_pin_enable_q <= 3'h0; // [R7]
			chan_pin_enable_q <= 3'h0; // [R8]
		end else if (wr_routing) begin
			// Each field sits in a byte lane of its own
			// Out-of-range location is ignored, keeping a valid pin set [R6]
			if (avs_byteenable_i[2] && avs_writedata_i[route_loc_pos +: 3] <= loc_max) begin
				location_q <= avs_writedata_i[route_loc_pos +: 3]; // [R6]
			end
			if (avs_byteenable_i[1]) begin
				comp_pin_enable_q <= avs_writedata_i[route_comp_pos +: 3]; // [R7]
			end
			if (avs_byteenable_i[0]) begin
				chan_pin_enable_q <= avs_writedata_i[route_chan_pos +: 3]; // [R8]
			end
		end
	end

	// ----------------------------------------
	// Output generation enables
	// ----------------------------------------
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			comp_gen_enable_q <= 3'h0;
			chan_gen_enable_q <= 3'h0;
		end else if (wr_out_enables && avs_byteenable_i[0]) begin
			comp_gen_enable_q <= avs_writedata_i[gen_comp_pos +: 3]; // [R9]
			chan_gen_enable_q <= avs_writedata_i[gen_chan_pos +: 3]; // [R10]
		end
	end

	// ----------------------------------------
	// Pin location output
	// ----------------------------------------
	// Extra flop keeps the output straight from a register, one cycle late
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			pin_location_o <= 3'h0;
		end else begin
			pin_location_o <= location_q; // [R6]
		end
	end

	// ----------------------------------------
	// Dead-time fault enables
	// ----------------------------------------
	// Enable bits follow the status bit layout
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			fault_enables_q <= 4'h0;
		end else if (wr_fault_enables && avs_byteenable_i[0]) begin
			fault_enables_q <= avs_writedata_i[3:0];
		end
	end

	// ----------------------------------------
	// Dead-time fault flags
	// ----------------------------------------
	assign fault_src = {core_lockup_i, debugger_fault_i, reflex_event_fault_i};

	// Set wins over a clear in the same cycle so no fault is lost
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			fault_flags_q <= 4'h0;
		end else begin
			fault_flags_q <= (fault_flags_q & ~(wr_fault_clear ? wdata[3:0] : 4'h0)) // [R16]
				| (fault_src & fault_enables_q); // [R12] [R13] [R14] [R15]
		end
	end
	// Any latched fault turns every bridge switch off
	assign fault_any = |fault_flags_q;

	// ----------------------------------------
	// Output gating
	// ----------------------------------------
	// Gated pins come from flops so a fault cannot glitch them
	generate
		for (genvar ch = 0; ch < 3; ch++) begin : g_gate
			dead_time_gate u_gate (
				.clk_sys_i(clk_sys_i),
				.rst_i(rst_i),
				.pwm_i(pwm_i[ch]),
				.gen_primary_i(chan_gen_enable_q[ch]), // [R10]
				.gen_comp_i(comp_gen_enable_q[ch]), // [R9] [R11]
				.pin_primary_i(chan_pin_enable_q[ch]), // [R8]
				.pin_comp_i(comp_pin_enable_q[ch]), // [R7]
				.fault_i(fault_any),
				.primary_o(gated_chan[ch]),
				.comp_o(gated_comp[ch])
			);
		end
	endgenerate
	assign chan_pin_o = gated_chan;
	assign comp_pin_o = gated_comp;

	// ----------------------------------------
	// Interrupt flags
	// ----------------------------------------
	// One overflow detector per capture channel
	generate
		for (genvar ch = 0; ch < 3; ch++) begin : g_chan
			capture_overflow u_ovf (
				.clk_sys_i(clk_sys_i),
				.rst_i(rst_i),
				.capture_i(capture_i[ch]),
				.read_i(capture_read_i[ch]),
				.overflow_o(overflow_evt[ch])
			);
		end
	endgenerate

	// Flags only ever set here; clearing lives outside this slice [R3]
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			overflow_flags_q <= 3'h0;
			event_flags_q <= 2'h0;
		end else begin
			overflow_flags_q <= overflow_flags_q | overflow_evt // [R4]
				| (wr_flag_set ? wdata[flag_ovf_pos +: 3] : 3'h0); // [R1]
			event_flags_q <= event_flags_q
				| (wr_flag_set ? wdata[flag_cc1_pos +: 2] : 2'h0); // [R2]
		end
	end
endmodule : timer_dead_time_route_regs

// ### timer_regs_chk.sv
// Port checker of the timer register slice.
// Assumes it is bound onto timer_dead_time_route_regs.
`timescale 1ns/1ns
module timer_regs_chk
	import timer_regs_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	input wire logic count_tick_i,
	input wire logic [2:0] chan_pin_o,
	input wire logic [2:0] comp_pin_o,
	input wire logic [2:0] pin_location_o,
	input wire logic [15:0] count_value_o
);
	// ----------------------------------------
	// Bus and register checks
	// ----------------------------------------
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	sequence s_req;
		(avs_read_i || avs_write_i) && avs_waitrequest_o;
	endsequence
	sequence s_ans;
		!avs_waitrequest_o ##1 avs_waitrequest_o;
	endsequence
	wire logic rd_done = avs_read_i && !avs_waitrequest_o;
	chk_bus_answer: assert property (s_req |-> ##[1:2] s_ans)
		else $error("bus answer missing");
	chk_flagset_zero: assert property (rd_done && avs_address_i == addr_flag_set |-> avs_readdata_o == 32'h0)
		else $error("flag set reads nonzero");
	chk_fault_rsvd: assert property (rd_done && avs_address_i == addr_fault_status |-> avs_readdata_o[31:4] == 28'h0)
		else $error("fault status spare bits set");
	chk_loc_range: assert property (pin_location_o <= loc_max)
		else $error("location out of range");
	// Location may only move in answer to a bus write
	chk_loc_cause: assert property ($changed(pin_location_o) |-> $past(avs_write_i) || $past(avs_write_i, 2))
		else $error("location moved without write");
	// Both switches of one half-bridge never on together
	chk_bridge_safe: assert property ((chan_pin_o & comp_pin_o) == 3'h0)
		else $error("primary and complement both high");
	chk_count_tick: assert property (count_tick_i && !avs_write_i |=> count_value_o == $past(count_value_o) + 16'h1)
		else $error("counter missed a tick");
	chk_count_hold: assert property (!count_tick_i && !avs_write_i |=> $stable(count_value_o))
		else $error("counter moved while idle");
	chk_wait_idle: assert property (!avs_read_i && !avs_write_i && avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("waitrequest dropped while idle");
	chk_route_spare: assert property (rd_done && avs_address_i == addr_routing |-> avs_readdata_o[31:19] == 13'h0)
		else $error("routing spare bits set");
endmodule : timer_regs_chk

bind timer_dead_time_route_regs timer_regs_chk timer_regs_chk_inst (.clk_sys_i, .rst_i, .avs_address_i, .avs_read_i,
	.avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .count_tick_i, .chan_pin_o, .comp_pin_o, .pin_location_o,
	.count_value_o);

// ### timer_dead_time_route_regs_bench.sv
// Self-checking bench of the timer register slice.
// Assumes the package offsets and a one-wait-cycle Avalon-MM slave.
`timescale 1ns/1ns
module timer_dead_time_route_regs_bench;
	import timer_regs_pkg::*;
	// ----------------------------------------
	// Signals and design
	// ----------------------------------------
	logic clk_sys_i, rst_i, avs_read_i, avs_write_i, avs_waitrequest_o, count_tick_i, core_lockup_i, debugger_fault_i;
	logic [7:0] avs_address_i;
	logic [31:0] avs_writedata_i, avs_readdata_o, rd;
	logic [3:0] avs_byteenable_i;
	logic [2:0] capture_i, capture_read_i, pwm_i, chan_pin_o, comp_pin_o, pin_location_o;
	logic [1:0] reflex_event_fault_i;
	logic [15:0] count_value_o;
	int fails = 0, tests_run = 0, cyc = 0;
	timer_dead_time_route_regs timer_dead_time_route_regs_inst (.clk_sys_i, .rst_i, .avs_address_i, .avs_read_i,
		.avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .count_tick_i,
		.capture_i, .capture_read_i, .pwm_i, .core_lockup_i, .debugger_fault_i, .reflex_event_fault_i, .chan_pin_o,
		.comp_pin_o, .pin_location_o, .count_value_o);
	initial begin
		clk_sys_i = 0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	// Whole run needs a few hundred cycles; ceiling leaves wide margin
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			final_report();
		end
	end
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic final_report();
		$display("tests_run=%0d fails=%0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : final_report
	task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask : tick
	// Request held until waitrequest is sampled low; data taken at that edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= w;
		avs_read_i <= !w;
		do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
		rd = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
		@(posedge clk_sys_i);
	endtask : bus
	task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		check(n, e, rd);
	endtask : rdchk
	task automatic set_src(input logic [3:0] s);
		{core_lockup_i, debugger_fault_i, reflex_event_fault_i} <= s;
		tick(2);
	endtask : set_src
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		rdchk("routing", addr_routing, 32'h0);
		rdchk("gen", addr_out_enables, 32'h0);
		rdchk("fault", addr_fault_status, 32'h0);
		rdchk("count", addr_counter, 32'h0);
		rdchk("flags", addr_flags, 32'h0);
	endtask : t_reset
	// Channel 0 fills its value and buffer pair and then one more
	task automatic t_capture();
		for (int i = 0; i < 3; i++) begin
			capture_i <= 3'h3;
			tick(1);
			capture_i <= 3'h0;
			capture_read_i <= 3'h2;
			tick(1);
			capture_read_i <= 3'h0;
		end
		tick(2);
		rdchk("overflow", addr_flags, 32'h100);
	endtask : t_capture
	task automatic t_flag_set();
		int bits[5] = '{8, 9, 10, 5, 6};
		logic [31:0] e;
		e = 32'h100;
		foreach (bits[i]) begin
			e[bits[i]] = 1'b1;
			bus(1'b1, addr_flag_set, 32'h1 << bits[i]);
			rdchk("flag", addr_flags, e);
		end
		bus(1'b1, addr_flag_set, 32'h0);
		rdchk("flag zero", addr_flags, e);
		rdchk("flag set", addr_flag_set, 32'h0);
	endtask : t_flag_set
	// Load near the top so the ticks wrap
	task automatic t_counter();
		bus(1'b1, addr_counter, 32'h0000_fffe);
		check("count load", 32'hfffe, count_value_o);
		count_tick_i <= 1'b1;
		tick(3);
		count_tick_i <= 1'b0;
		tick(1);
		check("count wrap", 32'h1, count_value_o);
		rdchk("count read", addr_counter, 32'h1);
	endtask : t_counter
	task automatic t_routing();
		for (int l = 0; l < 6; l++) begin
			bus(1'b1, addr_routing, (l << 16) | 32'h707);
			tick(1);
			check("location", l, pin_location_o);
		end
		rdchk("routing", addr_routing, 32'h0005_0707);
		bus(1'b1, addr_routing, 32'h0006_0707);
		tick(1);
		check("location", 32'h5, pin_location_o);
		rdchk("unmapped", 8'h40, 32'h0);
	endtask : t_routing
	task automatic t_outputs();
		pwm_i <= 3'h6;
		bus(1'b1, addr_out_enables, 32'h3f);
		tick(2);
		check("chan", 32'h6, chan_pin_o);
		check("comp", 32'h1, comp_pin_o);
		bus(1'b1, addr_out_enables, 32'h0c);
		tick(2);
		check("chan", 32'h4, chan_pin_o);
		check("comp", 32'h1, comp_pin_o);
		bus(1'b1, addr_out_enables, 32'h04);
		tick(2);
		check("comp off", 32'h0, comp_pin_o);
		bus(1'b1, addr_out_enables, 32'h0c);
		bus(1'b1, addr_routing, 32'h0005_0100);
		tick(2);
		check("chan", 32'h0, chan_pin_o);
		check("comp", 32'h1, comp_pin_o);
		bus(1'b1, addr_routing, 32'h0005_0707);
		bus(1'b1, addr_out_enables, 32'h3f);
	endtask : t_outputs
	task automatic t_faults();
		set_src(4'hf);
		set_src(4'h0);
		rdchk("fault off", addr_fault_status, 32'h0);
		bus(1'b1, addr_fault_enables, 32'hf);
		for (int i = 0; i < 4; i++) begin
			set_src(4'h1 << i);
			tick(1);
			check("forced", 32'h0, chan_pin_o);
			check("forced comp", 32'h0, comp_pin_o);
			set_src(4'h0);
			rdchk("fault", addr_fault_status, 32'h1 << i);
			bus(1'b1, addr_fault_status, 32'hf);
			rdchk("fault ro", addr_fault_status, 32'h1 << i);
			bus(1'b1, addr_fault_clear, 32'h1 << i);
			rdchk("fault clr", addr_fault_status, 32'h0);
			check("released", 32'h6, chan_pin_o);
		end
	endtask : t_faults
	initial begin
		{rst_i, avs_read_i, avs_write_i, count_tick_i, avs_address_i, avs_writedata_i} = {1'b1, 43'h0};
		{capture_i, capture_read_i, pwm_i, core_lockup_i, debugger_fault_i, reflex_event_fault_i} = 13'h0;
		avs_byteenable_i = 4'hf;
		tick(4);
		rst_i <= 1'b0;
		tick(1);
		t_reset();
		t_capture();
		t_flag_set();
		t_counter();
		t_routing();
		t_outputs();
		t_faults();
		final_report();
	end
endmodule : timer_dead_time_route_regs_bench
